// File: rtl/jtx_link_tx.sv
/*
  jtx_link_tx: 8b/10b transmit link layer: framing, scrambling, code group sync,
  lane alignment sequence, alignment characters, per-lane 10-bit code groups.
  Assumes sync_n_i and sysref_i are synchronous to clk_sys_i; one octet per lane per clock;
  samples_i holds the next frame and is taken when frame_taken_o says so.
*/
`timescale 1ns/1ns

// ----------------------------------------------------------------
// transmitter top
// ----------------------------------------------------------------
module jtx_link_tx
  import jtx_pkg::*;
#(
  parameter int LANES = 4,
  parameter int FMAX  = 8
) (
  input  wire logic                      clk_sys_i,
  input  wire logic                      rstn_i,
  input  wire logic [1:0]                link_format_select_i,
  input  wire logic                      scramble_enable_i,
  input  wire logic                      sync_n_i,
  input  wire logic                      sysref_i,
  input  wire logic [LANES*FMAX*8-1:0]   samples_i,
  output logic      [LANES*10-1:0]       lane_code_o,
  output logic                           frame_taken_o,
  output logic                           link_up_o,
  output logic                           lmfc_edge_o
);
  typedef struct packed {
    jtx_state_t                state;
    logic                      sync_n;
    logic                      sysref;
    logic                      scr_en;
    logic [1:0]                sel;
    logic [10:0]               lmfc;
    logic [3:0]                oct;
    logic [1:0]                mf;
    logic [LANES-1:0][14:0]    scramble_enable;
    logic [LANES-1:0][7:0]     last;
    logic [LANES-1:0][7:0]     octet;
    logic [LANES-1:0]          is_k;
    logic [LANES*FMAX*8-1:0]   frame;
    logic                      taken;
    logic                      up;
    logic                      lmfc_edge;
  } jtx_st_t;

  jtx_st_t     st_q;
  jtx_st_t     st_d;
  jtx_mode_t   md;
  logic [10:0] lmfc_last;
  logic        frame_end;
  logic        mf_end;
  logic [7:0]  lane0_s;

  jtx_enc_if #(.LANES(LANES)) eif ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // octet b of a frame: 16-bit samples, high byte first
  function automatic logic [7:0] get_oct(input logic [LANES*FMAX*8-1:0] v, input int b);
    return v[(b / 2) * 16 + ((b % 2 == 0) ? 8 : 0) +: 8];
  endfunction

  function automatic logic [7:0] cfg_byte(input int lane, input logic [10:0] pos,
                                          input jtx_mode_t m, input logic [1:0] sel,
                                          input logic scramble_enable);
    logic [7:0] b;
    unique case (3'(pos - ILAS_CFG_POS))
      3'd0:    b = 8'(lane);
      3'd1:    b = 8'(LANES - 1);
      3'd2:    b = {4'h0, m.f - 4'h1};
      3'd3:    b = 8'(m.k - 9'h001);
      3'd4:    b = {6'h00, sel};
      default: b = {7'h00, scramble_enable};
    endcase
    return b;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] d;
    logic [7:0] s;
    logic [14:0] ns;
    d = '0;
    s = '0;
    ns = '0;
    st_d = st_q;
    st_d.sync_n = sync_n_i;
    st_d.sysref = sysref_i;
    st_d.taken = 1'b0;
    md = jtx_mode_dec(st_q.sel);
    lmfc_last = 11'(md.f * md.k) - 11'h001;
    frame_end = (st_q.oct == md.f - 4'h1);
    mf_end = (st_q.lmfc == lmfc_last);
    lane0_s = '0;

    // multiframe counter
    if ((sysref_i && !st_q.sysref) || mf_end) begin
      st_d.lmfc = '0;
      st_d.oct = '0;
    end else begin
      st_d.lmfc = st_q.lmfc + 11'h001;
      st_d.oct = frame_end ? 4'h0 : st_q.oct + 4'h1;
    end
    st_d.lmfc_edge = (st_d.lmfc == 11'h000);

    // link sequence
    unique case (st_q.state)
      S_CGS: begin
        st_d.sel = link_format_select_i;
        st_d.scr_en = scramble_enable_i;
        if (sync_n_i && !st_q.sync_n) begin
          st_d.state = S_WAIT;
        end
      end
      S_WAIT: begin
        if (st_d.lmfc == 11'h000) begin
          st_d.state = S_ILAS;
          st_d.mf = '0;
        end
      end
      S_ILAS: begin
        if (mf_end) begin
          st_d.mf = st_q.mf + 2'h1;
          if (st_q.mf == ILAS_LAST_MF) begin
            st_d.state = S_DATA;
          end
        end
      end
      S_DATA: begin
        if (st_q.oct == 4'h0) begin
          st_d.frame = samples_i;
          st_d.taken = 1'b1;
        end
      end
    endcase
    if (!sync_n_i) begin
      st_d.state = S_CGS;
    end

    // octet per lane for this cycle
    for (int l = 0; l < LANES; l++) begin
      st_d.is_k[l] = 1'b0;
      unique case (st_q.state)
        S_CGS, S_WAIT: begin
          st_d.octet[l] = K28_5;
          st_d.is_k[l] = 1'b1;
          st_d.scramble_enable[l] = SCR_SEED;
        end
        S_ILAS: begin
          st_d.scramble_enable[l] = SCR_SEED;
          st_d.last[l] = LAST_RST;
          if (st_q.lmfc == 11'h000) begin
            st_d.octet[l] = K28_0;
            st_d.is_k[l] = 1'b1;
          end else if (mf_end) begin
            st_d.octet[l] = K28_3;
            st_d.is_k[l] = 1'b1;
          end else if (st_q.mf == ILAS_CFG_MF && st_q.lmfc == ILAS_Q_POS) begin
            st_d.octet[l] = K28_4;
            st_d.is_k[l] = 1'b1;
          end else if (st_q.mf == ILAS_CFG_MF && st_q.lmfc <= ILAS_CFG_END) begin
            st_d.octet[l] = cfg_byte(l, st_q.lmfc, md, st_q.sel, st_q.scr_en);
          end else begin
            st_d.octet[l] = st_q.lmfc[7:0];
          end
        end
        S_DATA: begin
          d = (st_q.oct == 4'h0) ? get_oct(samples_i, l * FMAX)
                                 : get_oct(st_q.frame, l * FMAX + int'(st_q.oct));
          if (st_q.scr_en) begin
            {ns, s} = jtx_scr_oct(d, st_q.scramble_enable[l]);
            st_d.scramble_enable[l] = ns;
          end else begin
            s = d;
          end
          st_d.octet[l] = s;
          if (frame_end) begin
            st_d.last[l] = s;
            if (!st_q.scr_en && s == st_q.last[l]) begin
              st_d.octet[l] = mf_end ? K28_3 : K28_7;
              st_d.is_k[l] = 1'b1;
            end else if (st_q.scr_en && mf_end && s == ALIGN_A_DATA) begin
              st_d.is_k[l] = 1'b1;
            end else if (st_q.scr_en && !mf_end && s == ALIGN_F_DATA) begin
              st_d.is_k[l] = 1'b1;
            end
          end
          if (l == 0) begin
            lane0_s = s;
          end
        end
      endcase
    end
    st_d.up = (st_d.state == S_DATA);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      st_q <= '0;
      st_q.sync_n <= SYNC_N_RST;
      st_q.scramble_enable <= {LANES{SCR_SEED}};
      st_q.last <= {LANES{LAST_RST}};
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // line encoder and outputs
  // ----------------------------------------------------------------
  assign eif.octet = st_q.octet;
  assign eif.is_k = st_q.is_k;

  jtx_enc #(.LANES(LANES)) u_enc (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .eif       (eif.enc)
  );

  assign lane_code_o = eif.code;
  assign frame_taken_o = st_q.taken;
  assign link_up_o = st_q.up;
  assign lmfc_edge_o = st_q.lmfc_edge;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  a_cgs_comma: assert property (st_q.state == S_CGS |=> st_q.is_k[0] && st_q.octet[0] == K28_5)
    else $error("no comma during sync request");
  a_sync_restart: assert property (!sync_n_i |=> st_q.state == S_CGS)
    else $error("sync low did not restart link");
  a_ilas_on_edge: assert property ($rose(st_q.state == S_ILAS) |-> st_q.lmfc == 11'h000)
    else $error("alignment sequence off multiframe edge");
  a_ilas_r_char: assert property (st_q.state == S_ILAS && st_q.lmfc == 11'h000
                                  |=> st_q.is_k[0] && st_q.octet[0] == K28_0)
    else $error("multiframe start not K28.0");
  a_ilas_a_char: assert property (st_q.state == S_ILAS && mf_end
                                  |=> st_q.is_k[0] && st_q.octet[0] == K28_3)
    else $error("multiframe end not K28.3");
  a_ilas_cfg_q: assert property (st_q.state == S_ILAS && st_q.mf == ILAS_CFG_MF &&
                                 st_q.lmfc == ILAS_Q_POS |=> st_q.octet[0] == K28_4)
    else $error("config multiframe marker missing");
  a_ilas_unscr: assert property (st_q.state == S_ILAS |=> st_q.scramble_enable[0] == SCR_SEED)
    else $error("scrambler ran during alignment sequence");
  a_sysref_lmfc: assert property (sysref_i && !st_q.sysref |=> st_q.lmfc == 11'h000)
    else $error("sysref did not reset multiframe counter");
  a_k_range: assert property (st_q.state == S_DATA |-> int'(md.k) * int'(md.f) >= K_MIN_OCT &&
                              int'(md.k) <= K_MAX && int'(md.k) * int'(md.f) <= FK_MAX)
    else $error("frames per multiframe out of range");
  a_scr_bypass: assert property (st_q.state == S_DATA && !st_q.scr_en && sync_n_i
                                 |=> $stable(st_q.scramble_enable))
    else $error("scrambler advanced while disabled");
  a_align_f: assert property (st_q.state == S_DATA && !st_q.scr_en && frame_end && !mf_end &&
                              lane0_s == st_q.last[0] |=> st_q.is_k[0] && st_q.octet[0] == K28_7)
    else $error("repeated frame end not replaced");
  a_align_scr: assert property (st_q.state == S_DATA && st_q.scr_en && mf_end &&
                                lane0_s == ALIGN_A_DATA |=> st_q.is_k[0])
    else $error("scrambled multiframe end not replaced");

  c_ilas_start: cover property ($rose(st_q.state == S_ILAS));
  c_link_up: cover property ($rose(st_q.up));
  c_align_char: cover property (st_q.state == S_DATA && st_q.is_k[0]);
  c_resync: cover property (st_q.up ##1 !sync_n_i);
endmodule

// File: include/jtx_pkg.sv
/*
  jtx_pkg: constants, types and shared functions of the 8b/10b link transmitter.
  Assumes a single 50 MHz clock domain; no software-visible registers.
*/
package jtx_pkg;
  // ----------------------------------------------------------------
  // control characters and alignment data values
  // ----------------------------------------------------------------
  localparam logic [7:0] K28_0 = 8'h1c;
  localparam logic [7:0] K28_3 = 8'h7c;
  localparam logic [7:0] K28_4 = 8'h9c;
  localparam logic [7:0] K28_5 = 8'hbc;
  localparam logic [7:0] K28_7 = 8'hfc;
  localparam logic [7:0] ALIGN_A_DATA = 8'h7c;
  localparam logic [7:0] ALIGN_F_DATA = 8'hfc;
  localparam logic [5:0] K28_6B = 6'h0f;

  // ----------------------------------------------------------------
  // reset values, counts and limits
  // ----------------------------------------------------------------
  localparam logic [14:0] SCR_SEED = 15'h0000;
  localparam logic [7:0]  LAST_RST = 8'h00;
  localparam logic        SYNC_N_RST = 1'b1;
  localparam logic [1:0]  ILAS_LAST_MF = 2'h3;
  localparam logic [1:0]  ILAS_CFG_MF = 2'h1;
  localparam logic [10:0] ILAS_Q_POS = 11'h001;
  localparam logic [10:0] ILAS_CFG_POS = 11'h002;
  localparam logic [10:0] ILAS_CFG_END = 11'h007;
  localparam int          K_MIN_OCT = 17;
  localparam int          K_MAX = 256;
  localparam int          FK_MAX = 1024;

  typedef enum logic [1:0] {S_CGS, S_WAIT, S_ILAS, S_DATA} jtx_state_t;

  typedef struct packed {
    logic [3:0] f;
    logic [8:0] k;
  } jtx_mode_t;

  // ----------------------------------------------------------------
  // link format table: frame length and frames per multiframe
  // ----------------------------------------------------------------
  function automatic jtx_mode_t jtx_mode_dec(input logic [1:0] sel);
    jtx_mode_t m;
    unique case (sel)
      2'h0: m = '{f: 4'h2, k: 9'h020};
      2'h1: m = '{f: 4'h4, k: 9'h010};
      2'h2: m = '{f: 4'h8, k: 9'h020};
      2'h3: m = '{f: 4'h1, k: 9'h020};
    endcase
    return m;
  endfunction

  // self-synchronous 1 + x^14 + x^15 scrambler, msb first; returns {state, octet}
  function automatic logic [22:0] jtx_scr_oct(input logic [7:0] d, input logic [14:0] s);
    logic [14:0] st;
    logic [7:0]  o;
    st = s;
    o = '0;
    for (int i = 7; i >= 0; i--) begin
      o[i] = d[i] ^ st[14] ^ st[13];
      st = {st[13:0], o[i]};
    end
    return {st, o};
  endfunction
endpackage

// File: include/jtx_enc_if.sv
/*
  jtx_enc_if: octet stream from the link logic to the line encoder, code groups back.
  Assumes both ends share clk_sys_i.
*/
`timescale 1ns/1ns
interface jtx_enc_if #(parameter int LANES = 4);
  logic [LANES-1:0][7:0] octet;
  logic [LANES-1:0]      is_k;
  logic [LANES-1:0][9:0] code;
  modport src (output octet, output is_k, input code);
  modport enc (input octet, input is_k, output code);
endinterface

// File: rtl/jtx_enc.sv
/*
  jtx_enc: per-lane 8b/10b encoder with running disparity, one code group per clock.
  Assumes octet and is_k are held by the source for the cycle they are sampled.
*/
`timescale 1ns/1ns
module jtx_enc
  import jtx_pkg::*;
#(
  parameter int LANES = 4
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  jtx_enc_if.enc   eif
);
  // ----------------------------------------------------------------
  // code tables, negative running disparity column
  // ----------------------------------------------------------------
  localparam logic [5:0] T6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] T4 [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

  typedef struct packed {
    logic [LANES-1:0]      rd;
    logic [LANES-1:0][9:0] code;
  } jtx_enc_st_t;

  jtx_enc_st_t st_q;
  jtx_enc_st_t st_d;

  // returns {next disparity, abcdei fghj}
  function automatic logic [10:0] enc10(input logic [7:0] d, input logic k, input logic rd);
    logic [5:0] c6;
    logic [3:0] c4;
    logic [4:0] x;
    logic [2:0] y;
    logic       r;
    logic       rm;
    logic       alt;
    logic [9:0] c;
    x = d[4:0];
    y = d[7:5];
    r = rd & ~k;
    c6 = k ? K28_6B : T6[x];
    if (r && (($countones(c6) != 3) || (!k && x == 5'd7))) begin
      c6 = ~c6;
    end
    rm = ($countones(c6) != 3) ? ~r : r;
    alt = (y == 3'd7) && (k || (!rm && (x == 5'd17 || x == 5'd18 || x == 5'd20)) ||
                          (rm && (x == 5'd11 || x == 5'd13 || x == 5'd14)));
    c4 = alt ? 4'h7 : T4[y];
    if (rm && (($countones(c4) != 2) || y == 3'd3)) begin
      c4 = ~c4;
    end
    c = {c6, c4};
    if (k && rd) begin
      c = ~c;
    end
    return {(($countones(c) != 5) ? ~rd : rd), c};
  endfunction

  // ----------------------------------------------------------------
  // encode all lanes
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    for (int l = 0; l < LANES; l++) begin
      {st_d.rd[l], st_d.code[l]} = enc10(eif.octet[l], eif.is_k[l], st_q.rd[l]);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign eif.code = st_q.code;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  // the first code group after reset is still the all-zero reset value
  a_code_weight: assert property ($past(rstn_i) |->
                                  $countones(st_q.code[0]) inside {4, 5, 6})
    else $error("code group weight out of range");
  a_rd_follow: assert property ($past(rstn_i) && $countones(st_q.code[0]) != 5 |->
                                st_q.rd[0] != $past(st_q.rd[0]))
    else $error("running disparity not flipped");
endmodule

// File: bench/jtx_rx_model.sv
/*
  jtx_rx_model: behavioural receiving end of the link; drives SYNC and SYSREF.
  Assumes the transmitter clock is shared; only lane 0 code groups are watched.
*/
`timescale 1ns/1ns
module jtx_rx_model (
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic        start_i,
  input  wire logic [10:0] mf_len_i,
  input  wire logic [9:0]  lane_code_i,
  output logic             sync_n_o,
  output logic             sysref_o
);
  logic [10:0] lmfc_q;
  logic [2:0]  comma_q;
  logic        req_q;
  logic        is_comma;

  // ----------------------------------------------------------------
  // request, comma count and release on the local multiframe edge
  // ----------------------------------------------------------------
  assign is_comma = (lane_code_i == 10'h0fa) || (lane_code_i == 10'h305);

  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      lmfc_q   <= 11'h000;
      comma_q  <= 3'h0;
      req_q    <= 1'b0;
      sync_n_o <= 1'b1;
      sysref_o <= 1'b0;
    end else begin
      // a single pulse ahead of every request, also before a restart
      sysref_o <= start_i;
      if (sysref_o || lmfc_q == mf_len_i - 11'h001) begin
        lmfc_q <= 11'h000;
      end else begin
        lmfc_q <= lmfc_q + 11'h001;
      end
      if (sysref_o) begin
        req_q    <= 1'b1;
        sync_n_o <= 1'b0;
        comma_q  <= 3'h0;
      end else if (req_q) begin
        if (!is_comma) begin
          comma_q <= 3'h0;
        end else if (comma_q != 3'h4) begin
          comma_q <= comma_q + 3'h1;
        end
        if (comma_q == 3'h4 && lmfc_q == 11'h000) begin
          sync_n_o <= 1'b1;
          req_q    <= 1'b0;
        end
      end
    end
  end
endmodule

// File: bench/tb_top.sv
/*
  tb_top: self-checking bench of the link transmitter, six rows: every link format unscrambled, formats 0 and 3 also scrambled.
  Assumes the receiver model drives SYNC and SYSREF; code groups are classed by K28 kind.
*/
`timescale 1ns/1ns
module tb_top
  import jtx_pkg::*;
;
  localparam int         LANES = 4;
  localparam int         FMAX  = 8;
  localparam logic [3:0] KR    = 4'h4;
  localparam logic [3:0] KA    = 4'h3;
  localparam logic [3:0] KQ    = 4'h2;
  localparam logic [3:0] KC    = 4'ha;
  localparam logic [3:0] KF    = 4'h8;
  localparam logic [3:0] KD    = 4'h0;

  typedef struct packed {
    logic [1:0] sel;
    logic       scramble;
    int         f;
    int         mf;
  } jtx_row_t;

  logic                    clk_sys_i;
  logic                    rstn_i;
  logic [1:0]              link_format_select_i;
  logic                    scramble_enable_i;
  logic                    sync_n_i;
  logic                    sysref_i;
  logic [LANES*FMAX*8-1:0] samples_i;
  logic [LANES*10-1:0]     lane_code_o;
  logic                    frame_taken_o;
  logic                    link_up_o;
  logic                    lmfc_edge_o;
  logic                    start_q;
  logic [10:0]             mf_len;
  logic [LANES-1:0]        rd_pos;
  int                      err_count;
  int                      comparisons;
  int                      cyc;
  int                      t0;
  int                      ones;
  jtx_row_t                rows [6] = '{'{2'h0, 1'b0, 2, 64}, '{2'h1, 1'b0, 4, 64},
                                        '{2'h2, 1'b0, 8, 256}, '{2'h3, 1'b0, 1, 32},
                                        '{2'h0, 1'b1, 2, 64}, '{2'h3, 1'b1, 1, 32}};

  jtx_link_tx #(.LANES(LANES), .FMAX(FMAX)) dut (
    .clk_sys_i            (clk_sys_i),
    .rstn_i               (rstn_i),
    .link_format_select_i (link_format_select_i),
    .scramble_enable_i    (scramble_enable_i),
    .sync_n_i             (sync_n_i),
    .sysref_i             (sysref_i),
    .samples_i            (samples_i),
    .lane_code_o          (lane_code_o),
    .frame_taken_o        (frame_taken_o),
    .link_up_o            (link_up_o),
    .lmfc_edge_o          (lmfc_edge_o)
  );

  jtx_rx_model partner (
    .clk_sys_i   (clk_sys_i),
    .rstn_i      (rstn_i),
    .start_i     (start_q),
    .mf_len_i    (mf_len),
    .lane_code_i (lane_code_o[9:0]),
    .sync_n_o    (sync_n_i),
    .sysref_o    (sysref_i)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // ----------------------------------------------------------------
  // helpers and compare tasks
  // ----------------------------------------------------------------
  function automatic logic [3:0] kind(input logic [9:0] c);
    if (c[9:4] === K28_6B) return c[3:0];
    if (c[9:4] === ~K28_6B) return ~c[3:0];
    return KD;
  endfunction

  function automatic logic [3:0] ilas_kind(input int i, input int mf);
    if (i % mf == 0) return KR;
    if (i % mf == mf - 1) return KA;
    if (i == mf + 1) return KQ;
    return KD;
  endfunction

  task automatic tick;
    @(posedge clk_sys_i);
    #2;
    cyc++;
  endtask

  task automatic fail(input string m);
    err_count++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic chk_kind(input logic [3:0] got, input logic [3:0] exp, input string m);
    comparisons++;
    if (got !== exp) fail(m);
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string m);
    comparisons++;
    if (got !== exp) fail(m);
  endtask

  task automatic chk_num(input int got, input int exp, input string m);
    comparisons++;
    if (got != exp) fail(m);
  endtask

  task automatic chk_lanes(input logic [3:0] exp, input string m);
    for (int l = 0; l < LANES; l++) chk_kind(kind(lane_code_o[l*10+:10]), exp, m);
  endtask

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      fail("wait limit reached");
      summarize();
    end
  endtask

  // running disparity of every lane, tracked from the reset state
  always @(posedge clk_sys_i) begin
    for (int l = 0; l < LANES; l++) begin
      ones = $countones(lane_code_o[l*10+:10]);
      if (!rstn_i) rd_pos[l] = 1'b0;
      else if (lane_code_o[l*10+:10] !== 10'h000) begin
        comparisons++;
        if (ones == 6 && !rd_pos[l]) rd_pos[l] = 1'b1;
        else if (ones == 4 && rd_pos[l]) rd_pos[l] = 1'b0;
        else if (ones != 5) fail("code group disparity");
      end
    end
  end

  // ----------------------------------------------------------------
  // scenario tasks
  // ----------------------------------------------------------------
  task automatic do_reset;
    rstn_i = 1'b0;
    repeat (3) tick;
    chk_bit(link_up_o, 1'b0, "link up in reset");
    chk_bit(frame_taken_o, 1'b0, "frame taken in reset");
    rstn_i = 1'b1;
    repeat (3) tick;
    chk_lanes(KC, "no comma after reset");
  endtask

  task automatic link_start(input jtx_row_t r);
    int         n;
    logic [2:0] hist;
    hist = 3'h0;
    start_q = 1'b1;
    tick;
    start_q = 1'b0;
    n = 0;
    while (sync_n_i !== 1'b0 && n < 8) begin tick; n++; end
    bound(n, 8);
    n = 0;
    while (sync_n_i !== 1'b1 && n < 600) begin
      tick;
      n++;
      if (n > 3) chk_lanes(KC, "no comma while sync low");
      if (n > 3) chk_bit(link_up_o, 1'b0, "link up while sync low");
    end
    bound(n, 600);
    n = 0;
    while (kind(lane_code_o[9:0]) === KC && n < r.mf + 6) begin
      hist = {hist[1:0], lmfc_edge_o};
      tick;
      n++;
    end
    bound(n, r.mf + 6);
    chk_bit(|hist, 1'b1, "alignment start off multiframe edge");
    chk_lanes(KR, "alignment start");
    t0 = cyc;
    for (int i = 1; i <= 4 * r.mf; i++) begin
      tick;
      if (i == 4 * r.mf - 4) chk_bit(link_up_o, 1'b0, "link up early");
      if (i == 4 * r.mf) chk_bit(link_up_o, 1'b1, "link not up");
      else chk_lanes(ilas_kind(i, r.mf), "alignment sequence");
    end
  endtask

  task automatic data_checks(input jtx_row_t r);
    int         n;
    int         p;
    int         cnt;
    logic [3:0] ea;
    logic [3:0] k;
    int         chg;
    logic [9:0] prev;
    n = 0;
    while (frame_taken_o !== 1'b1 && n < 20) begin tick; n++; end
    bound(n, 20);
    n = 0;
    do begin tick; n++; end while (frame_taken_o !== 1'b1 && n < 20);
    chk_num(n, r.f, "frame period");
    repeat (2) begin
      n = 0;
      do begin tick; n++; end while (lmfc_edge_o !== 1'b1 && n < 600);
      bound(n, 600);
    end
    chk_num(n, r.mf, "multiframe period");
    chk_bit(n % r.f == 0 && n / r.f >= (K_MIN_OCT + r.f - 1) / r.f
            && n / r.f <= K_MAX && n <= FK_MAX, 1'b1, "frames per multiframe");
    cnt = 0;
    chg = 0;
    prev = lane_code_o[9:0];
    for (int i = 0; i < 2 * r.mf; i++) begin
      tick;
      if (lane_code_o[9:0] !== prev) chg++;
      prev = lane_code_o[9:0];
      p = (cyc - t0) % r.mf;
      ea = (p == r.mf - 1) ? KA : ((p % r.f == r.f - 1) ? KF : KD);
      if (!r.scramble) chk_lanes(ea, "alignment character");
      else for (int l = 0; l < LANES; l++) begin
        k = kind(lane_code_o[l*10+:10]);
        if (k !== KD) cnt++;
        if (k !== KD) chk_kind(k, ea, "scrambled alignment character");
      end
    end
    if (r.scramble) chk_bit(cnt < 8, 1'b1, "data not scrambled");
    // constant samples give one fixed data code group (D5.5) unless the scrambler runs
    if (r.scramble) chk_bit(chg > r.mf / 2, 1'b1, "scrambled data constant");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn_i = 1'b0;
    start_q = 1'b0;
    link_format_select_i = 2'h0;
    scramble_enable_i = 1'b0;
    mf_len = 11'h040;
    samples_i = {(LANES*FMAX){8'ha5}};
    err_count = 0;
    comparisons = 0;
    cyc = 0;
    foreach (rows[i]) begin
      link_format_select_i = rows[i].sel;
      scramble_enable_i = rows[i].scramble;
      mf_len = 11'(rows[i].mf);
      do_reset();
      link_start(rows[i]);
      data_checks(rows[i]);
      $display("format %0d scramble %0d done", rows[i].sel, rows[i].scramble);
    end
    // restart from the data state: sync pulled low again after a new sysref
    link_start(rows[5]);
    $display("restart done");
    // reset in mid-run: sync stays high, so the link must not start
    do_reset();
    for (int i = 0; i < 2 * rows[5].mf; i++) begin
      tick;
      chk_lanes(KC, "comma lost after reset");
    end
    chk_bit(link_up_o, 1'b0, "link up without sync request");
    $display("mid-run reset done");
    summarize();
  end
endmodule
